// ==== design/ccs_deglitch.sv ====
// Per-bit persistence filter for status conditions.
// Assumes inputs synchronous to clk; masked-out bits pass with one flop.
`timescale 1ns/1ps
`default_nettype none
module ccs_deglitch #(
  parameter int          CYCLES = 800000,
  parameter logic [15:0] MASK   = 16'hFFFF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Raw and filtered conditions
  input  wire logic [15:0] raw,
  output logic      [15:0] filt
);
  import ccs_pkg::*;

  localparam logic [CCS_CNT_W-1:0] LAST = CCS_CNT_W'(CYCLES - 1);

  typedef struct packed {
    logic [15:0]                out;
    logic [15:0][CCS_CNT_W-1:0] cnt;
  } ccs_dg_state_s;

  ccs_dg_state_s st_q;
  ccs_dg_state_s st_d;

  // ****************************************************************
  // Filter
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < 16; i++) begin
      if (!MASK[i] || raw[i] == st_q.out[i]) begin
        st_d.out[i] = raw[i];
        st_d.cnt[i] = '0;
      end else if (st_q.cnt[i] == LAST) begin
        st_d.out[i] = raw[i];
        st_d.cnt[i] = '0;
      end else begin
        st_d.cnt[i] = st_q.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign filt = st_q.out;

  // A filtered bit only moves to a level its input already holds
  property p_deglitch_follow;
    @(posedge clk) disable iff (reset)
      $changed(st_q.out) |->
        ((st_q.out ^ $past(raw)) & ($past(st_q.out) ^ st_q.out) & MASK) == 16'h0000;
  endproperty
  a_deglitch_follow: assert property (p_deglitch_follow)
    else $error("deglitched bit changed to a level not held at input");

endmodule
`default_nettype wire

// ==== design/ccs_pkg.sv ====
// Package for the charger control and status register block.
// Holds command codes, control and status field positions, reset values
// and timing counts; assumes a 100 MHz core clock.
package ccs_pkg;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0]  CCS_CMD_CONTROL   = 8'h12;
  localparam logic [7:0]  CCS_CMD_STATUS    = 8'h13;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int          CCS_B_STOP        = 0;
  localparam int          CCS_B_POR_RESET   = 2;
  localparam int          CCS_B_FREQ        = 5;
  localparam int          CCS_B_OCEN        = 6;
  localparam int          CCS_B_RATIO       = 7;
  localparam int          CCS_B_DEPL        = 9;
  localparam logic [15:0] CCS_CTRL_WMASK    = 16'h0FE1;
  localparam logic [15:0] CCS_CTRL_RESET    = 16'h0000;

  // ****************************************************************
  // Status register fields
  // ****************************************************************
  localparam int          CCS_S_NOT_READY   = 0;
  localparam int          CCS_S_NOT_ON      = 1;
  localparam int          CCS_S_DEPL_BATT   = 6;
  localparam int          CCS_S_DEPL_ADPT   = 7;
  localparam int          CCS_S_DEPL        = 11;
  localparam logic [15:0] CCS_STATUS_RESET  = 16'h0003;
  localparam logic [15:0] CCS_DEGLITCH_MASK = 16'hFFFC;

  // ****************************************************************
  // Thresholds and ratios
  // ****************************************************************
  localparam logic [8:0]  CCS_DEPL_BASE_CV  = 9'h0DC;  // 2.2 V in 10 mV units
  localparam logic [8:0]  CCS_DEPL_STEP_CV  = 9'h00A;  // 0.1 V
  localparam logic [4:0]  CCS_RATIO_BASE    = 5'h0D;   // 1.3 in tenths
  localparam logic [4:0]  CCS_RATIO_STEP    = 5'h02;   // 0.2 in tenths
  localparam logic [3:0]  CCS_RATIO_SCALE   = 4'hA;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CCS_CLK_KHZ       = 100000;
  localparam int          CCS_DEGLITCH_MS   = 8;
  localparam int          CCS_DEGLITCH_CYC  = CCS_DEGLITCH_MS * CCS_CLK_KHZ;
  localparam int          CCS_CNT_W         = 20;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        por_done;
    logic        adapter_present;
    logic        gate_drive_rail;
    logic        charge_inhibit_pin;
    logic [8:0]  cell_voltage_cv;
    logic [15:0] input_current_limit;
    logic [15:0] adapter_current;
    logic [15:0] sensed_status;
  } ccs_sense_s;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  cmd;
    logic [15:0] wr_data;
  } ccs_host_s;

endpackage

// ==== design/ccs_regs.sv ====
// Charger control and status registers with alert and enable logic.
// Assumes the command framing is decoded outside; one strobe per access.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - control bit 5 picks 500 kHz when set, 300 kHz when clear; resets clear.
// - control bit 6 enables adapter overcurrent protection.
// - ratio field acts only while bit 6 is high.
// - overcurrent threshold is input limit times 1.3, 1.5, 1.7 or 1.9.
// - three-bit depletion code selects 2.2 V to 2.9 V per cell.
// - depletion selection drives status bits 11, 6 and 7.
// - charging only when stop bit and inhibit pin are both low.
// - status bits update by themselves as conditions change.
// - chosen status bits change only after 8 ms persistence.
// - any status bit change pulls the alert low.
// - alert stays low until status is read, then released.
// - status bit 0 means not ready; starts at 1.
// - not-ready clears only with reset done, adapter and gate rail ready.
module ccs_regs #(
  parameter int DEGLITCH_CYCLES = ccs_pkg::CCS_DEGLITCH_CYC
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Register access
  input  wire ccs_pkg::ccs_host_s  host,
  output logic              [15:0] rd_data,
  // Conditions sensed in the device
  input  wire ccs_pkg::ccs_sense_s sense,
  // Controls to the power stage
  output logic                     charge_enable,
  output logic                     switch_freq_sel,
  output logic              [20:0] oc_threshold_x10,
  output logic                     adapter_overcurrent,
  // Open-drain alert
  output logic                     alert_out,
  output logic                     alert_oe
);
  import ccs_pkg::*;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] status;
    logic [15:0] rd_data;
    logic        charge_enable;
    logic        switch_freq_sel;
    logic [20:0] oc_thr;
    logic        adapter_overcurrent;
    logic        alert_oe;
  } ccs_state_s;

  ccs_state_s  st_q;
  ccs_state_s  st_d;
  logic [15:0] raw_status;
  logic [15:0] filt_status;
  logic [8:0]  depl_cv;
  logic        depleted;
  logic [4:0]  ratio;
  logic        ctrl_wr;
  logic        status_rd;
  logic        not_ready;

  // ****************************************************************
  // Condition decode
  // ****************************************************************
  always_comb begin
    ctrl_wr   = host.wr_en && host.cmd == CCS_CMD_CONTROL;
    status_rd = host.rd_en && host.cmd == CCS_CMD_STATUS;
    depl_cv   = CCS_DEPL_BASE_CV
              + 9'(st_q.ctrl[CCS_B_DEPL +: 3] * CCS_DEPL_STEP_CV);
    depleted  = sense.cell_voltage_cv < depl_cv;
    ratio     = CCS_RATIO_BASE
              + 5'(st_q.ctrl[CCS_B_RATIO +: 2] * CCS_RATIO_STEP);
    not_ready = !(sense.por_done && sense.adapter_present
                  && sense.gate_drive_rail);
    raw_status                  = sense.sensed_status;
    raw_status[CCS_S_NOT_READY] = 1'b0;
    raw_status[CCS_S_NOT_ON]    = 1'b0;
    raw_status[CCS_S_DEPL]      = depleted;
    raw_status[CCS_S_DEPL_BATT] = depleted && !sense.adapter_present;
    raw_status[CCS_S_DEPL_ADPT] = depleted && sense.adapter_present;
  end

  // ****************************************************************
  // Status deglitch
  // ****************************************************************
  ccs_deglitch #(
    .CYCLES (DEGLITCH_CYCLES),
    .MASK   (CCS_DEGLITCH_MASK)
  ) u_deglitch (
    .clk    (clk),
    .reset  (reset),
    .raw    (raw_status),
    .filt   (filt_status)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    if (ctrl_wr) begin
      if (host.wr_data[CCS_B_POR_RESET]) begin
        st_d.ctrl = CCS_CTRL_RESET;
      end else begin
        st_d.ctrl = host.wr_data & CCS_CTRL_WMASK;
      end
    end
    st_d.switch_freq_sel = st_q.ctrl[CCS_B_FREQ];
    st_d.charge_enable   = !st_q.ctrl[CCS_B_STOP]
                         && !sense.charge_inhibit_pin && !not_ready;
    // Threshold kept in tenths so every ratio stays exact
    st_d.oc_thr = st_q.ctrl[CCS_B_OCEN]
                ? 21'(sense.input_current_limit) * 21'(ratio) : '0;
    st_d.adapter_overcurrent = st_q.ctrl[CCS_B_OCEN]
                && 21'(sense.adapter_current) * 21'(CCS_RATIO_SCALE) > st_q.oc_thr;
    st_d.status                  = filt_status;
    st_d.status[CCS_S_NOT_READY] = not_ready;
    st_d.status[CCS_S_NOT_ON]    = !st_q.charge_enable;
    st_d.rd_data = status_rd ? st_q.status : 16'h0000;
    // Set wins over the read clear, so no change is ever lost
    st_d.alert_oe = (st_d.status != st_q.status)
                  || (st_q.alert_oe && !status_rd);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q          <= '0;
      st_q.ctrl     <= CCS_CTRL_RESET;
      st_q.status   <= CCS_STATUS_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rd_data             = st_q.rd_data;
  assign charge_enable       = st_q.charge_enable;
  assign switch_freq_sel     = st_q.switch_freq_sel;
  assign oc_threshold_x10    = st_q.oc_thr;
  assign adapter_overcurrent = st_q.adapter_overcurrent;
  assign alert_out           = 1'b0;
  assign alert_oe            = st_q.alert_oe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_ctrl_write;
    ctrl_wr && !host.wr_data[CCS_B_POR_RESET];
  endsequence

  property p_freq;
    @(posedge clk) disable iff (reset)
      s_ctrl_write |=> ##1 switch_freq_sel == $past(host.wr_data[CCS_B_FREQ], 2);
  endproperty
  a_freq: assert property (p_freq)
    else $error("switch frequency select does not follow control bit");

  property p_oc_off;
    @(posedge clk) disable iff (reset)
      !st_q.ctrl[CCS_B_OCEN] |=> !adapter_overcurrent && oc_threshold_x10 == '0;
  endproperty
  a_oc_off: assert property (p_oc_off)
    else $error("overcurrent active while protection disabled");

  property p_oc_thr;
    @(posedge clk) disable iff (reset)
      st_q.ctrl[CCS_B_OCEN] && st_q.ctrl[CCS_B_RATIO +: 2] == 2'h3
        |=> oc_threshold_x10 == 21'($past(sense.input_current_limit) * 19);
  endproperty
  a_oc_thr: assert property (p_oc_thr)
    else $error("overcurrent threshold not limit times 1.9");

  property p_charge_block;
    @(posedge clk) disable iff (reset)
      st_q.ctrl[CCS_B_STOP] || sense.charge_inhibit_pin |=> !charge_enable;
  endproperty
  a_charge_block: assert property (p_charge_block)
    else $error("charger enabled while stop bit or inhibit pin high");

  property p_not_ready;
    @(posedge clk) disable iff (reset)
      not_ready |=> st_q.status[CCS_S_NOT_READY];
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("not-ready flag clear without all precursors");

  property p_alert_set;
    @(posedge clk) disable iff (reset)
      $changed(st_q.status) |-> alert_oe;
  endproperty
  a_alert_set: assert property (p_alert_set)
    else $error("status changed without alert");

  property p_alert_hold;
    @(posedge clk) disable iff (reset)
      alert_oe && !status_rd |=> alert_oe;
  endproperty
  a_alert_hold: assert property (p_alert_hold)
    else $error("alert released without status read");

  property p_alert_clear;
    @(posedge clk) disable iff (reset)
      status_rd && st_d.status == st_q.status |=> !alert_oe;
  endproperty
  a_alert_clear: assert property (p_alert_clear)
    else $error("alert not released after status read");

  property p_unused_zero;
    @(posedge clk) disable iff (reset)
      ctrl_wr |=> st_q.ctrl[15:12] == 4'h0 && !st_q.ctrl[1];
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused control bit took a written value");

endmodule
`default_nettype wire

// ==== tb/ccs_host_model.sv ====
// Host model for the charger register block: issues register accesses.
// Assumes one free-running clk; requests change on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module ccs_host_model (
  // Clock
  input  wire logic               clk,
  // Register access
  output var  ccs_pkg::ccs_host_s host,
  input  wire logic        [15:0] rd_data,
  // Open-drain alert
  input  wire logic               alert_out,
  input  wire logic               alert_oe,
  output logic                    alert_n
);
  import ccs_pkg::*;

  // External pull-up holds the line high whenever the device lets go
  assign alert_n = alert_oe ? alert_out : 1'b1;

  initial host = '0;

  task automatic write_ctrl(input logic [15:0] d);
    @(negedge clk);
    host = '{wr_en: 1'b1, rd_en: 1'b0, cmd: CCS_CMD_CONTROL, wr_data: d};
    @(negedge clk);
    host = '0;
  endtask

  // A status read is the only way the host releases the alert
  task automatic read_status(output logic [15:0] d);
    @(negedge clk);
    host = '{wr_en: 1'b0, rd_en: 1'b1, cmd: CCS_CMD_STATUS, wr_data: 16'h0000};
    @(negedge clk);
    host = '0;
    // Read data stands for one cycle only, so take it now
    d = rd_data;
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the charger control and status registers.
// Assumes the host model in the same folder; deglitch shortened to 8.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccs_pkg::*;
  localparam int DG = 8;

  typedef struct packed {
    logic [15:0] ctrl;
    logic        inh;
    logic [15:0] cur;
    logic        freq;
    logic        en;
    logic [20:0] oc;
    logic        ovc;
  } ccs_row_s;

  // Input limit is fixed at 0x64, so thresholds are 0x64 times the ratio
  localparam ccs_row_s ROWS [12] = '{
    '{16'h0000, 1'b0, 16'h00C8, 1'b0, 1'b1, 21'h00000, 1'b0},
    '{16'h0020, 1'b0, 16'h00C8, 1'b1, 1'b1, 21'h00000, 1'b0},
    '{16'h0021, 1'b0, 16'h00C8, 1'b1, 1'b0, 21'h00000, 1'b0},
    '{16'h0020, 1'b1, 16'h00C8, 1'b1, 1'b0, 21'h00000, 1'b0},
    '{16'h0040, 1'b0, 16'h0081, 1'b0, 1'b1, 21'h00514, 1'b0},
    '{16'h0040, 1'b0, 16'h0083, 1'b0, 1'b1, 21'h00514, 1'b1},
    '{16'h00C0, 1'b0, 16'h0097, 1'b0, 1'b1, 21'h005DC, 1'b1},
    '{16'h0064, 1'b0, 16'h00C8, 1'b0, 1'b1, 21'h00000, 1'b0},
    '{16'h0140, 1'b0, 16'h0081, 1'b0, 1'b1, 21'h006A4, 1'b0},
    '{16'h01C0, 1'b0, 16'h0081, 1'b0, 1'b1, 21'h0076C, 1'b0},
    '{16'h0180, 1'b0, 16'h00C8, 1'b0, 1'b1, 21'h00000, 1'b0},
    '{16'hF01A, 1'b0, 16'h00C8, 1'b0, 1'b1, 21'h00000, 1'b0}
  };

  logic               clk;
  logic               reset;
  ccs_host_s          host;
  ccs_sense_s         sense;
  logic        [15:0] rd_data;
  logic               charge_enable;
  logic               switch_freq_sel;
  logic        [20:0] oc_threshold_x10;
  logic               adapter_overcurrent;
  logic               alert_out;
  logic               alert_oe;
  logic               alert_n;
  int                 n_errors;
  int                 checks_done;

  ccs_regs #(.DEGLITCH_CYCLES(DG)) uut (
    .clk                 (clk),
    .reset               (reset),
    .host                (host),
    .rd_data             (rd_data),
    .sense               (sense),
    .charge_enable       (charge_enable),
    .switch_freq_sel     (switch_freq_sel),
    .oc_threshold_x10    (oc_threshold_x10),
    .adapter_overcurrent (adapter_overcurrent),
    .alert_out           (alert_out),
    .alert_oe            (alert_oe)
  );

  ccs_host_model host_m (
    .clk       (clk),
    .host      (host),
    .rd_data   (rd_data),
    .alert_out (alert_out),
    .alert_oe  (alert_oe),
    .alert_n   (alert_n)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [20:0] exp, input logic [20:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks made %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Run needs under a thousand cycles; ten thousand means a hang
  initial begin
    #100us;
    n_errors++;
    give_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [15:0] st;
    logic        dep;
    logic        adp;
    n_errors = 0;
    checks_done = 0;
    sense = '0;
    sense.cell_voltage_cv = 9'h190;
    sense.input_current_limit = 16'h0064;
    reset = 1'b1;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    check("switch_freq_sel", 1'b0, switch_freq_sel);
    host_m.read_status(st);
    check("not_ready_flag", 1'b1, st[0]);
    check("status upper", 14'h0000, st[15:2]);
    // Each precursor missing in turn, then all present
    for (int i = 0; i < 4; i++) begin
      {sense.por_done, sense.adapter_present, sense.gate_drive_rail} =
        (i == 3) ? 3'h7 : ~(3'h1 << i);
      repeat (3) @(negedge clk);
      host_m.read_status(st);
      check("not_ready_flag", i != 3, st[0]);
    end
    foreach (ROWS[i]) begin
      host_m.write_ctrl(ROWS[i].ctrl);
      sense.charge_inhibit_pin = ROWS[i].inh;
      sense.adapter_current = ROWS[i].cur;
      repeat (4) @(negedge clk);
      check("switch_freq_sel", ROWS[i].freq, switch_freq_sel);
      check("charge_enable", ROWS[i].en, charge_enable);
      check("oc_threshold_x10", ROWS[i].oc, oc_threshold_x10);
      check("adapter_overcurrent", ROWS[i].ovc, adapter_overcurrent);
    end
    repeat (3) host_m.read_status(st);
    check("alert idle", 1'b1, alert_n);
    // A pulse shorter than the filter must not reach status
    sense.sensed_status[4] = 1'b1;
    repeat (DG - 2) @(negedge clk);
    sense.sensed_status[4] = 1'b0;
    repeat (DG + 4) @(negedge clk);
    check("alert after glitch", 1'b1, alert_n);
    sense.sensed_status[4] = 1'b1;
    repeat (DG + 4) @(negedge clk);
    check("alert on change", 1'b0, alert_n);
    host_m.read_status(st);
    check("status bit 4", 1'b1, st[4]);
    check("alert after read", 1'b1, alert_n);
    sense.sensed_status[4] = 1'b0;
    repeat (DG + 4) @(negedge clk);
    check("alert again", 1'b0, alert_n);
    // Every depletion code, just below and at its threshold
    for (int k = 0; k < 16; k++) begin
      dep = ~k[0];
      adp = k[1];
      host_m.write_ctrl({4'h0, 3'(k / 2), 9'h000});
      sense.adapter_present = adp;
      sense.cell_voltage_cv = 9'(9'h0DC + 9'h00A * (k / 2) - dep);
      repeat (DG + 4) @(negedge clk);
      host_m.read_status(st);
      check("depletion bits", {4'h0, dep, 3'h0, dep & adp, dep & ~adp, 6'h00},
            st & 16'h08C0);
    end
    // Reset in mid-run must bring control back to its defaults
    host_m.write_ctrl(16'h0060);
    repeat (3) @(negedge clk);
    check("switch_freq_sel", 1'b1, switch_freq_sel);
    check("oc_threshold_x10", 21'h00514, oc_threshold_x10);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    check("alert in reset", 1'b1, alert_n);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    check("switch_freq_sel", 1'b0, switch_freq_sel);
    check("oc_threshold_x10", 21'h00000, oc_threshold_x10);
    give_verdict();
  end
endmodule
`default_nettype wire
